// file: design/bank1_sfr_bank.sv
// Bank 1 special register block behind an APB slave port
`timescale 1ns/100ps
// Overview of operation
// - Unmapped addresses in this bank read zero; writes there change nothing.
// - Bank-independent registers are one physical register seen from every bank.
// - Program counter high byte has no direct read or write path.
// - Five-bit latch is copied into counter bits 12..8 on low-byte update.
// - Bits with unknown reset value start at zero; nothing relies on them.
// - Reset cause flags take values from the reset condition that occurred.
module bank1_sfr_bank
    import bank1_sfr_pkg::*;
(
    // APB clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB request
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    // APB answer
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,
    // Core side: program counter
    input wire logic pc_step,
    output logic [12:0] program_counter,
    // Core side: arithmetic flags
    input wire logic alu_flags_we,
    input wire logic [2:0] alu_flags,
    // Core side: indirect data access
    input wire logic [7:0] indirect_rdata,
    output logic indirect_we,
    output logic [8:0] indirect_addr,
    output logic [7:0] indirect_wdata,
    // Reset cause pins
    input wire logic power_on_reset,
    input wire logic brown_out_reset,
    // Peripheral status
    input wire logic [5:0] serial_port_flags,
    input wire logic [7:0] converter_result_low,
    // Register contents to the peripherals
    output logic [7:0] processor_status,
    output logic [7:0] option_config,
    output logic [7:0] port_a_direction,
    output logic [7:0] port_b_direction,
    output logic [7:0] port_c_direction,
    output logic [7:0] interrupt_control,
    output logic [7:0] peripheral_irq_enable_one,
    output logic [7:0] peripheral_irq_enable_two,
    output logic [7:0] serial_port_control_two,
    output logic [7:0] timer_period,
    output logic [7:0] serial_port_slave_address,
    output logic [1:0] serial_port_mode,
    output logic [7:0] converter_config_one,
    output logic [1:0] reset_cause_flags
);
    index_t idx;
    logic addr_ok;
    logic setup;
    logic wr_access;
    logic [7:0] wbyte;
    logic [7:0] gen_q [NGEN];
    logic [NGEN-1:0] gen_hit;
    logic hit_indirect;
    logic hit_pc_low;
    logic hit_status;
    logic hit_cause;
    logic hit_ser_state;
    logic hit_conv_low;
    logic any_hit;
    logic [7:0] rd_byte;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic [PC_W-1:0] pc_reg;
    logic [PC_W-1:0] pc_next;
    logic [7:0] status_reg;
    logic [7:0] status_next;
    logic [7:0] ser_state_reg;
    logic [7:0] ser_state_next;
    logic indirect_we_reg;
    logic [8:0] indirect_addr_reg;
    logic [7:0] indirect_wdata_reg;
    logic [1:0] cause_flags;
    logic cause_loaded;
    logic first_cycle_reg;

    // Address decode
    assign idx = paddr[IDX_MSB:IDX_LSB];
    assign addr_ok = !paddr[ADDR_TOP];
    assign setup = psel && !penable;
    assign wr_access = psel && penable && pwrite && pstrb[0] && addr_ok;
    assign wbyte = pwdata[7:0];

    assign hit_indirect = addr_ok && idx_hit(idx, IDX_INDIRECT_DATA, 1'b1);
    assign hit_pc_low = addr_ok && idx_hit(idx, IDX_PC_LOW, 1'b1);
    assign hit_status = addr_ok && idx_hit(idx, IDX_STATUS, 1'b1);
    assign hit_cause = addr_ok && idx_hit(idx, IDX_CAUSE, 1'b0);
    assign hit_ser_state = addr_ok && idx_hit(idx, IDX_SER_STATE, 1'b0);
    assign hit_conv_low = addr_ok && idx_hit(idx, IDX_CONV_LOW, 1'b0);
    assign any_hit = hit_indirect || hit_pc_low || hit_status || hit_cause || hit_ser_state || hit_conv_low
        || (|gen_hit);

    // Plain registers, one cell each
    genvar g;
    generate
        for (g = 0; g < NGEN; g++) begin : gen_cell
            assign gen_hit[g] = addr_ok && idx_hit(idx, GEN_INDEX[g], GEN_SHARED[g]);
            sfr_field_reg #(
                .RESET(GEN_RESET[g]),
                .MASK(GEN_MASK[g])
            ) u_cell (
                .pclk(pclk),
                .presetn(presetn),
                .we(wr_access && gen_hit[g]),
                .wdata(wbyte),
                .q(gen_q[g])
            );
        end
    endgenerate

    reset_cause_capture u_cause (
        .pclk(pclk),
        .presetn(presetn),
        .power_on_reset(power_on_reset),
        .brown_out_reset(brown_out_reset),
        .we(wr_access && hit_cause),
        .wdata(wbyte[1:0]),
        .flags(cause_flags),
        .loaded(cause_loaded)
    );

    // Read multiplexer; no hit leaves zero
    always_comb begin
        rd_byte = 8'h00;
        for (int i = 0; i < NGEN; i++) begin
            if (gen_hit[i]) begin
                rd_byte = gen_q[i];
            end
        end
        if (hit_indirect) begin
            rd_byte = indirect_rdata;
        end
        if (hit_pc_low) begin
            rd_byte = pc_reg[7:0];
        end
        if (hit_status) begin
            rd_byte = status_reg;
        end
        if (hit_cause) begin
            rd_byte = {6'h00, cause_flags};
        end
        if (hit_ser_state) begin
            rd_byte = {ser_state_reg[7:6], serial_port_flags};
        end
        if (hit_conv_low) begin
            rd_byte = converter_result_low;
        end
    end

    // Read data is latched in the setup cycle, so pready can stay high
    assign prdata_next = setup ? {24'h000000, rd_byte} : prdata_reg;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign prdata = prdata_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h00000000;
        end else begin
            prdata_reg <= prdata_next;
        end
    end

    // Program counter: the latch moves only on a low-byte write
    assign pc_next = (wr_access && hit_pc_low) ? {gen_q[G_PC_LATCH][PC_LATCH_W-1:0], wbyte}
        : pc_step ? pc_reg + PC_ONE : pc_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_reg <= PC_RESET;
        end else begin
            pc_reg <= pc_next;
        end
    end

    // Status: timeout and power-down bits are not writable here
    assign status_next = (wr_access && hit_status) ? ((status_reg & ~STATUS_WMASK) | (wbyte & STATUS_WMASK))
        : alu_flags_we ? {status_reg[7:3], alu_flags} : status_reg;
    // Serial status keeps only its two mode bits
    assign ser_state_next = (wr_access && hit_ser_state) ? (wbyte & SER_STATE_WMASK) : ser_state_reg;

    // Flag bits of unknown reset value start at zero; no logic here depends on it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= STATUS_RESET;
            ser_state_reg <= SER_STATE_RESET;
        end else begin
            status_reg <= status_next;
            ser_state_reg <= ser_state_next;
        end
    end

    // Indirect write is registered, so the core sees it one cycle later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            indirect_we_reg <= 1'b0;
            indirect_addr_reg <= 9'h000;
            indirect_wdata_reg <= 8'h00;
            first_cycle_reg <= 1'b1;
        end else begin
            indirect_we_reg <= wr_access && hit_indirect;
            indirect_addr_reg <= {status_reg[STATUS_IND_PAGE], gen_q[G_POINTER]};
            indirect_wdata_reg <= wbyte;
            first_cycle_reg <= 1'b0;
        end
    end

    // Outputs
    assign program_counter = pc_reg;
    assign indirect_we = indirect_we_reg;
    assign indirect_addr = indirect_addr_reg;
    assign indirect_wdata = indirect_wdata_reg;
    assign processor_status = status_reg;
    assign option_config = gen_q[G_OPTION];
    assign port_a_direction = gen_q[G_DIR_A];
    assign port_b_direction = gen_q[G_DIR_B];
    assign port_c_direction = gen_q[G_DIR_C];
    assign interrupt_control = gen_q[G_IRQ_CTRL];
    assign peripheral_irq_enable_one = gen_q[G_IRQ_EN1];
    assign peripheral_irq_enable_two = gen_q[G_IRQ_EN2];
    assign serial_port_control_two = gen_q[G_SER_CTRL2];
    assign timer_period = gen_q[G_TMR_PERIOD];
    assign serial_port_slave_address = gen_q[G_SER_ADDR];
    assign serial_port_mode = ser_state_reg[7:6];
    assign converter_config_one = gen_q[G_CONV_CFG1];
    assign reset_cause_flags = cause_flags;

    // Checks
    unmapped_read_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !any_hit |=> prdata == 32'h00000000)
        else $error("unmapped read returned nonzero");

    unmapped_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_access && !any_hit && !pc_step && !alu_flags_we |=> $stable(pc_reg) && $stable(status_reg)
        && $stable(port_b_direction) && $stable(timer_period) && !indirect_we)
        else $error("unmapped write changed state");

    unused_bits_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        port_a_direction[7:6] == 2'h0 && gen_q[G_PC_LATCH][7:5] == 3'h0 && (peripheral_irq_enable_two & 8'he7) == 8'h00)
        else $error("unimplemented bits read nonzero");

    shared_pc_low_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_access && hit_pc_low && idx[8:7] != BANK_ONE |=> pc_reg[7:0] == $past(wbyte))
        else $error("shared low byte missed from other bank");

    pc_load_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_access && hit_pc_low |=> pc_reg[12:8] == $past(gen_q[G_PC_LATCH][4:0]))
        else $error("latch not copied into counter high bits");

    latch_no_jump_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_access && gen_hit[G_PC_LATCH] && !pc_step |=> $stable(pc_reg))
        else $error("latch write moved the counter");

    // Datapath checks
    latch_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_access && gen_hit[G_PC_LATCH] |=> gen_q[G_PC_LATCH] == ($past(wbyte) & GEN_MASK[G_PC_LATCH]))
        else $error("latch write not masked to five bits");

    pc_step_a: assert property (@(posedge pclk) disable iff (!presetn)
        !(wr_access && hit_pc_low) && pc_step |=> pc_reg == $past(pc_reg) + PC_ONE)
        else $error("counter did not step");

    prdata_upper_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        prdata[31:8] == 24'h000000)
        else $error("read data upper bits nonzero");

    status_ro_bits_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_access && hit_status |=> status_reg[4:3] == $past(status_reg[4:3]))
        else $error("read-only status bits written");

    alu_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
        alu_flags_we && !(wr_access && hit_status) |=> status_reg[2:0] == $past(alu_flags))
        else $error("core flags not stored");

    ser_state_bits_a: assert property (@(posedge pclk) disable iff (!presetn)
        ser_state_reg[5:0] == 6'h00)
        else $error("serial state stores live flag bits");

    // Shared and bank-bound decode
    indirect_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_access && hit_indirect |=> indirect_we && indirect_wdata == $past(wbyte))
        else $error("indirect write not passed on");

    indirect_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
        indirect_addr == $past({status_reg[STATUS_IND_PAGE], gen_q[G_POINTER]}))
        else $error("indirect address not from pointer");

    status_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        setup && hit_status |=> prdata[7:0] == $past(status_reg))
        else $error("status read wrong");

    bound_read_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        setup && idx[8:7] != BANK_ONE && idx[6:0] == IDX_DIR_A[6:0] |=> prdata == 32'h00000000)
        else $error("bank-bound register read from wrong bank");

    option_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_access && gen_hit[G_OPTION] |=> option_config == $past(wbyte))
        else $error("option write lost");

    dir_a_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_access && gen_hit[G_DIR_A] |=> port_a_direction == ($past(wbyte) & GEN_MASK[G_DIR_A]))
        else $error("direction A write not masked");

    // Software write counts only once the capture is done
    cause_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_access && hit_cause && cause_loaded |=> reset_cause_flags == $past(wbyte[1:0]))
        else $error("cause flags write lost");

    reset_pattern_a: assert property (@(posedge pclk) disable iff (!presetn)
        first_cycle_reg |-> option_config == 8'hff && port_a_direction == 8'h3f && port_b_direction == 8'hff
        && port_c_direction == 8'hff && timer_period == 8'hff && pc_reg == PC_RESET)
        else $error("reset pattern wrong");

    bank_miss_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_access && idx[8:7] != BANK_ONE && idx[6:0] == IDX_DIR_B[6:0] |=> $stable(port_b_direction))
        else $error("bank-bound register hit from wrong bank");

    cause_settles_a: assert property (@(posedge pclk) disable iff (!presetn)
        first_cycle_reg |-> ##[1:4] cause_loaded)
        else $error("reset cause flags never loaded");

    pc_low_write_c: cover property (@(posedge pclk) disable iff (!presetn) wr_access && hit_pc_low);
    pc_step_c: cover property (@(posedge pclk) disable iff (!presetn) pc_step);
    shared_from_bank0_c: cover property (@(posedge pclk) disable iff (!presetn) setup && hit_status && idx[8:7] == 2'h0);
    unmapped_read_c: cover property (@(posedge pclk) disable iff (!presetn) setup && !pwrite && !any_hit);
    indirect_write_c: cover property (@(posedge pclk) disable iff (!presetn) indirect_we);
endmodule : bank1_sfr_bank

// file: design/bank1_sfr_pkg.sv
// Constants, register map and field layouts of the bank 1 special register block
package bank1_sfr_pkg;

    // Register indices as printed; byte address is four times the index
    localparam logic [8:0] IDX_INDIRECT_DATA = 9'h080;
    localparam logic [8:0] IDX_OPTION = 9'h081;
    localparam logic [8:0] IDX_PC_LOW = 9'h082;
    localparam logic [8:0] IDX_STATUS = 9'h083;
    localparam logic [8:0] IDX_POINTER = 9'h084;
    localparam logic [8:0] IDX_DIR_A = 9'h085;
    localparam logic [8:0] IDX_DIR_B = 9'h086;
    localparam logic [8:0] IDX_DIR_C = 9'h087;
    localparam logic [8:0] IDX_PC_LATCH = 9'h08a;
    localparam logic [8:0] IDX_IRQ_CTRL = 9'h08b;
    localparam logic [8:0] IDX_IRQ_EN1 = 9'h08c;
    localparam logic [8:0] IDX_IRQ_EN2 = 9'h08d;
    localparam logic [8:0] IDX_CAUSE = 9'h08e;
    localparam logic [8:0] IDX_SER_CTRL2 = 9'h091;
    localparam logic [8:0] IDX_TMR_PERIOD = 9'h092;
    localparam logic [8:0] IDX_SER_ADDR = 9'h093;
    localparam logic [8:0] IDX_SER_STATE = 9'h094;
    localparam logic [8:0] IDX_CONV_LOW = 9'h09e;
    localparam logic [8:0] IDX_CONV_CFG1 = 9'h09f;

    // Address fields
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 10;
    localparam int ADDR_TOP = 11;

    // Plain read/write registers built from one masked cell each
    localparam int NGEN = 13;
    localparam int G_POINTER = 0;
    localparam int G_OPTION = 1;
    localparam int G_DIR_A = 2;
    localparam int G_DIR_B = 3;
    localparam int G_DIR_C = 4;
    localparam int G_PC_LATCH = 5;
    localparam int G_IRQ_CTRL = 6;
    localparam int G_IRQ_EN1 = 7;
    localparam int G_IRQ_EN2 = 8;
    localparam int G_SER_CTRL2 = 9;
    localparam int G_TMR_PERIOD = 10;
    localparam int G_SER_ADDR = 11;
    localparam int G_CONV_CFG1 = 12;

    typedef logic [7:0] byte_t;
    typedef logic [8:0] index_t;

    localparam index_t GEN_INDEX [NGEN] = '{IDX_POINTER, IDX_OPTION, IDX_DIR_A, IDX_DIR_B, IDX_DIR_C,
        IDX_PC_LATCH, IDX_IRQ_CTRL, IDX_IRQ_EN1, IDX_IRQ_EN2, IDX_SER_CTRL2, IDX_TMR_PERIOD, IDX_SER_ADDR,
        IDX_CONV_CFG1};
    localparam byte_t GEN_MASK [NGEN] = '{8'hff, 8'hff, 8'h3f, 8'hff, 8'hff,
        8'h1f, 8'hff, 8'h4f, 8'h18, 8'hff, 8'hff, 8'hff, 8'h8f};
    localparam byte_t GEN_RESET [NGEN] = '{8'h00, 8'hff, 8'h3f, 8'hff, 8'hff,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00};
    localparam logic [NGEN-1:0] GEN_SHARED = 13'h0061;

    // Status register layout
    localparam byte_t STATUS_RESET = 8'h18;
    localparam byte_t STATUS_WMASK = 8'he7;
    localparam int STATUS_IND_PAGE = 7;
    localparam int STATUS_RP_LSB = 5;
    localparam int STATUS_RP_MSB = 6;
    localparam logic [1:0] BANK_ONE = 2'h1;

    // Program counter
    localparam int PC_W = 13;
    localparam int PC_LATCH_W = 5;
    localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
    localparam logic [PC_W-1:0] PC_ONE = 13'h0001;

    // Serial status: only the two top bits are stored
    localparam byte_t SER_STATE_WMASK = 8'hc0;
    localparam byte_t SER_STATE_RESET = 8'h00;

    // Reset cause flags
    localparam int CAUSE_POWER_BIT = 1;
    localparam int CAUSE_BROWN_BIT = 0;
    localparam logic [1:0] CAUSE_RESET = 2'h0;
    localparam logic [1:0] CAUSE_WAIT = 2'h2;

    // Same register whether shared across banks or bound to this bank
    function automatic logic idx_hit(input index_t idx, input index_t target, input logic shared);
        idx_hit = shared ? (idx[6:0] == target[6:0]) : (idx == target);
    endfunction : idx_hit

endpackage : bank1_sfr_pkg

// file: design/reset_cause_capture.sv
// Reset cause flags: synchronised cause pins caught after reset release
`timescale 1ns/100ps
module reset_cause_capture
    import bank1_sfr_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Cause pins from the reset controller, asynchronous
    input wire logic power_on_reset,
    input wire logic brown_out_reset,
    // Software write
    input wire logic we,
    input wire logic [1:0] wdata,
    // Flags: a zero marks the reset that occurred
    output logic [1:0] flags,
    output logic loaded
);
    logic [1:0] sync1_reg;
    logic [1:0] sync2_reg;
    logic [1:0] wait_reg;
    logic [1:0] flags_reg;
    logic done_reg;
    logic load;

    assign load = !done_reg && (wait_reg == CAUSE_WAIT);
    assign flags = flags_reg;
    assign loaded = done_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= CAUSE_RESET;
            sync2_reg <= CAUSE_RESET;
        end else begin
            sync1_reg <= {power_on_reset, brown_out_reset};
            sync2_reg <= sync1_reg;
        end
    end

    // Wait out the synchroniser before trusting the cause levels
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_reg <= CAUSE_RESET;
            done_reg <= 1'b0;
        end else begin
            wait_reg <= (wait_reg == CAUSE_WAIT) ? wait_reg : wait_reg + 2'h1;
            done_reg <= done_reg | load;
        end
    end

    // Capture wins over a software write in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_reg <= CAUSE_RESET;
        end else if (load) begin
            flags_reg <= ~sync2_reg;
        end else if (we) begin
            flags_reg <= wdata;
        end
    end

    cause_from_pins_a: assert property (@(posedge pclk) disable iff (!presetn)
        load |=> flags_reg == ~$past(sync2_reg))
        else $error("reset cause flags not taken from cause pins");
endmodule : reset_cause_capture

// file: design/sfr_field_reg.sv
// One masked eight-bit register cell with its reset pattern
`timescale 1ns/100ps
module sfr_field_reg
    import bank1_sfr_pkg::*;
#(
    parameter byte_t RESET = 8'h00,
    parameter byte_t MASK = 8'hff
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Write side
    input wire logic we,
    input wire logic [7:0] wdata,
    // Stored value
    output logic [7:0] q
);
    logic [7:0] value_reg;
    logic [7:0] value_next;

    assign value_next = we ? (wdata & MASK) : value_reg;
    assign q = value_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value_reg <= RESET & MASK;
        end else begin
            value_reg <= value_next;
        end
    end
endmodule : sfr_field_reg

// file: verification/bank1_special_register_map_tb_top.sv
// Self-checking bench for the bank 1 special register block
`timescale 1ns/100ps
module bank1_special_register_map_tb_top
    import bank1_sfr_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic pc_step = 1'b0;
    logic alu_flags_we = 1'b0;
    logic [2:0] alu_flags = 3'h0;
    logic power_on_reset = 1'b0;
    logic brown_out_reset = 1'b0;
    logic [5:0] serial_port_flags = 6'h00;
    logic [7:0] converter_result_low = 8'h00;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [12:0] program_counter;
    logic [7:0] indirect_rdata;
    logic indirect_we;
    logic [8:0] indirect_addr;
    logic [7:0] indirect_wdata;
    logic [1:0] serial_port_mode;
    logic [1:0] reset_cause_flags;
    int num_errors = 0;
    int n_tests = 0;

    index_t rst_idx [11] = '{IDX_OPTION, IDX_DIR_A, IDX_DIR_B, IDX_DIR_C, IDX_TMR_PERIOD, IDX_PC_LATCH,
        IDX_PC_LOW, IDX_STATUS, IDX_SER_CTRL2, IDX_SER_ADDR, IDX_CONV_CFG1};
    byte_t rst_exp [11] = '{8'hff, 8'h3f, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h18, 8'h00, 8'h00, 8'h00};
    index_t msk_idx [6] = '{IDX_DIR_A, IDX_PC_LATCH, IDX_CONV_CFG1, IDX_OPTION, IDX_STATUS, IDX_STATUS};
    byte_t msk_wd [6] = '{8'hff, 8'hff, 8'hff, 8'h5a, 8'hff, 8'h00};
    byte_t msk_exp [6] = '{8'h3f, 8'h1f, 8'h8f, 8'h5a, 8'hff, 8'h18};
    index_t gap_idx [6] = '{9'h088, 9'h089, 9'h08f, 9'h090, 9'h095, 9'h09d};

    initial begin
        forever #12.5 pclk = ~pclk;
    end

    bank1_sfr_bank u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .pc_step(pc_step), .program_counter(program_counter), .alu_flags_we(alu_flags_we),
        .alu_flags(alu_flags), .indirect_rdata(indirect_rdata), .indirect_we(indirect_we),
        .indirect_addr(indirect_addr), .indirect_wdata(indirect_wdata), .power_on_reset(power_on_reset),
        .brown_out_reset(brown_out_reset), .serial_port_flags(serial_port_flags),
        .converter_result_low(converter_result_low), .processor_status(), .option_config(),
        .port_a_direction(), .port_b_direction(), .port_c_direction(), .interrupt_control(),
        .peripheral_irq_enable_one(), .peripheral_irq_enable_two(), .serial_port_control_two(),
        .timer_period(), .serial_port_slave_address(), .serial_port_mode(serial_port_mode),
        .converter_config_one(), .reset_cause_flags(reset_cause_flags));

    core_side_model u_core (.pclk(pclk), .indirect_we(indirect_we), .indirect_addr(indirect_addr),
        .indirect_wdata(indirect_wdata), .indirect_rdata(indirect_rdata));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done

    // Request held until pready is seen high at an access edge
    task automatic apb(input logic wr, input index_t idx, input byte_t wd, output logic [31:0] rd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {1'b0, idx, 2'b00};
        pwdata <= {24'h0, wd};
        pstrb <= 4'h1;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr_reg(input index_t idx, input byte_t wd);
        logic [31:0] rd;
        apb(1'b1, idx, wd, rd);
    endtask : wr_reg

    task automatic rd_chk(input index_t idx, input byte_t exp);
        logic [31:0] rd;
        apb(1'b0, idx, 8'h00, rd);
        check(rd, {24'h0, exp});
    endtask : rd_chk

    // Cause pins held steady well past the capture edges
    task automatic do_reset(input logic por, input logic bor);
        presetn <= 1'b0;
        power_on_reset <= por;
        brown_out_reset <= bor;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (5) @(posedge pclk);
    endtask : do_reset

    initial begin
        #(25 * 20000);
        num_errors++;
        test_done();
    end

    initial begin
        do_reset(1'b1, 1'b0);
        for (int i = 0; i < 11; i++) begin
            rd_chk(rst_idx[i], rst_exp[i]);
        end
        rd_chk(IDX_CAUSE, 8'h01);
        wr_reg(IDX_CAUSE, 8'h03);
        rd_chk(IDX_CAUSE, 8'h03);
        for (int i = 0; i < 6; i++) begin
            wr_reg(msk_idx[i], msk_wd[i]);
            rd_chk(msk_idx[i], msk_exp[i]);
        end
        wr_reg(IDX_IRQ_EN1, 8'h4f);
        rd_chk(IDX_IRQ_EN1, 8'h4f);
        wr_reg(IDX_IRQ_EN2, 8'h18);
        rd_chk(IDX_IRQ_EN2, 8'h18);
        for (int i = 0; i < 6; i++) begin
            wr_reg(gap_idx[i], 8'hff);
            rd_chk(gap_idx[i], 8'h00);
        end
        check({31'h0, pslverr}, 32'h0);
        // Shared latch written through bank 0, read through banks 2 and 3
        wr_reg(9'h00a, 8'h07);
        rd_chk(9'h18a, 8'h07);
        rd_chk(9'h10a, 8'h07);
        wr_reg(9'h105, 8'h00);
        rd_chk(IDX_DIR_A, 8'h3f);
        rd_chk(9'h185, 8'h00);
        wr_reg(9'h106, 8'h00);
        rd_chk(IDX_DIR_B, 8'hff);
        wr_reg(IDX_PC_LATCH, 8'h15);
        @(negedge pclk);
        check({19'h0, program_counter}, 32'h0);
        wr_reg(IDX_PC_LOW, 8'h34);
        @(negedge pclk);
        check({19'h0, program_counter}, 32'h1534);
        rd_chk(IDX_PC_LOW, 8'h34);
        @(posedge pclk);
        pc_step <= 1'b1;
        @(posedge pclk);
        pc_step <= 1'b0;
        @(negedge pclk);
        check({19'h0, program_counter}, 32'h1535);
        wr_reg(9'h002, 8'h40);
        rd_chk(9'h182, 8'h40);
        @(posedge pclk);
        alu_flags_we <= 1'b1;
        alu_flags <= 3'h5;
        @(posedge pclk);
        alu_flags_we <= 1'b0;
        rd_chk(IDX_STATUS, 8'h1d);
        wr_reg(IDX_POINTER, 8'h40);
        rd_chk(IDX_INDIRECT_DATA, 8'he5);
        wr_reg(9'h100, 8'h3c);
        // Memory takes the write one edge after the registered pulse
        @(posedge pclk);
        rd_chk(IDX_INDIRECT_DATA, 8'h3c);
        @(posedge pclk);
        converter_result_low <= 8'h5c;
        serial_port_flags <= 6'h2a;
        rd_chk(IDX_CONV_LOW, 8'h5c);
        wr_reg(IDX_SER_STATE, 8'hff);
        rd_chk(IDX_SER_STATE, 8'hea);
        check({30'h0, serial_port_mode}, 32'h3);
        // Second reset in mid-run from a brown-out
        do_reset(1'b0, 1'b1);
        rd_chk(IDX_CAUSE, 8'h02);
        check({30'h0, reset_cause_flags}, 32'h2);
        rd_chk(IDX_OPTION, 8'hff);
        rd_chk(IDX_PC_LATCH, 8'h00);
        test_done();
    end
endmodule : bank1_special_register_map_tb_top

// file: verification/core_side_model.sv
// Data memory seen by the core through the indirect access path
`timescale 1ns/100ps
module core_side_model
    import bank1_sfr_pkg::*;
(
    // Clock
    input wire logic pclk,
    // Indirect access from the block
    input wire logic indirect_we,
    input wire logic [8:0] indirect_addr,
    input wire logic [7:0] indirect_wdata,
    // Read data back to the block
    output logic [7:0] indirect_rdata
);
    byte_t mem [512];

    // Address-derived fill so a wrong pointer shows up as wrong data
    initial begin
        for (int i = 0; i < 512; i++) begin
            mem[i] = byte_t'(i) ^ 8'ha5;
        end
    end

    // Plain always: the memory is also filled by the initial block
    always @(posedge pclk) begin
        if (indirect_we) begin
            mem[indirect_addr] <= indirect_wdata;
        end
    end

    assign indirect_rdata = mem[indirect_addr];
endmodule : core_side_model
